// File: srap_port.sv
/*
 * srap_port: serial command front end, mode 3, command then data.
 * assumes: sclk, din and cs come from pins in another domain; clk_i is
 * many times faster than the serial clock.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - mode 3: shift out falling, sample rising
// - chip select may stay low forever
// - write-only 8-bit command register, reset zero
// - after reset first byte is command
// - low six bits select, bit six direction
// - after data phase, wait for command
// - 64 ones on din resets everything
// - chip select high aborts transfer
// - writes carry 8, 16 or 24 bits
// - reads shift out register width bits
// - read-only identification register at five
// - channel 0 default enabled, inputs zero/one
// - setup default unbuffered, gain one, external
// - control default low power, internal clock
// - only ignore-access diagnostic enabled
// - internal master clock is clk_i/16, 625 khz from 10 mhz (614.4 khz target)
module srap_port
    import srap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic mclk_o,
    output logic busy_o
);
    // synchronisers; first stages read only by second stages
    logic sclk_m_r, sclk_s_r, sclk_d_r;
    logic cs_m_r, cs_s_r;
    logic din_m_r, din_s_r;
    srap_state_e state_r; // interface state
    logic [7:0] cmd_r; // command register contents
    logic [23:0] sh_r; // shift register
    logic [5:0] cnt_r; // bits in current phase
    logic [5:0] len_r; // length of data phase
    logic [6:0] ones_r; // run of ones on din
    logic [4:0] div_r; // master clock divider
    logic mclk_r;
    logic clr_r; // resync full reset strobe
    logic dout_r;
    logic [23:0] rdata;
    logic [15:0] ctrl;
    logic we_r;
    // edges of the sampled serial clock
    wire rise = sclk_s_r & ~sclk_d_r;
    wire fall = ~sclk_s_r & sclk_d_r;
    wire abort = cs_s_r;
    wire [7:0] cmd_in = {sh_r[6:0], din_s_r};
    wire cmd_ok = ~cmd_in[SRAP_CMD_WEN_BIT];
    wire cmd_rd = cmd_in[SRAP_CMD_RD_BIT];
    wire [5:0] sel = cmd_r[5:0];
    // width of each register's data phase
    function automatic logic [5:0] reg_len(input logic [5:0] a);
        if (a == SRAP_ADDR_IDENT)
            reg_len = SRAP_LEN8;
        else if (a == SRAP_ADDR_ERREN)
            reg_len = SRAP_LEN24;
        else
            reg_len = SRAP_LEN16;
    endfunction
    assign busy_o = state_r != SRAP_ST_CMD;
    assign dout_o = dout_r;
    assign dout_oe_o = (state_r == SRAP_ST_RD) & ~cs_s_r;
    assign mclk_o = mclk_r;
    // pin synchronisers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_m_r <= 1'b1;
            sclk_s_r <= 1'b1;
            sclk_d_r <= 1'b1;
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
        end else begin
            sclk_m_r <= sclk_i;
            sclk_s_r <= sclk_m_r;
            sclk_d_r <= sclk_s_r;
            cs_m_r <= cs_b_i;
            cs_s_r <= cs_m_r;
            din_m_r <= din_i;
            din_s_r <= din_m_r;
        end
    end
    // internal master clock divider, free running
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_r <= 5'h00;
            mclk_r <= 1'b0;
        end else if (div_r == SRAP_MCLK_DIV - 5'h01) begin
            div_r <= 5'h00;
            mclk_r <= ~mclk_r;
        end else begin
            div_r <= div_r + 5'h01;
        end
    end
    // ones counter for the resync reset, counted on rising edges
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ones_r <= 7'h00;
            clr_r <= 1'b0;
        end else begin
            clr_r <= 1'b0;
            if (rise && !abort) begin
                if (!din_s_r) begin
                    ones_r <= 7'h00;
                end else if (ones_r == SRAP_RESYNC_ONES - 7'h01) begin
                    ones_r <= 7'h00;
                    clr_r <= 1'b1;
                end else begin
                    ones_r <= ones_r + 7'h01;
                end
            end
        end
    end
    // command and data state machine
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= SRAP_ST_CMD;
            cmd_r <= SRAP_CMD_RST;
            sh_r <= 24'h000000;
            cnt_r <= 6'h00;
            len_r <= 6'h00;
            dout_r <= 1'b1;
            we_r <= 1'b0;
        end else if (clr_r || abort) begin
            // resync reset or chip select high
            state_r <= SRAP_ST_CMD;
            cmd_r <= clr_r ? SRAP_CMD_RST : cmd_r;
            cnt_r <= 6'h00;
            dout_r <= 1'b1;
            we_r <= 1'b0;
        end else begin
            we_r <= 1'b0;
            case (state_r)
                SRAP_ST_CMD: begin
                    // cs may stay low; framing by counting bits
                    if (rise) begin
                        sh_r <= {sh_r[22:0], din_s_r};
                        if (cnt_r == SRAP_LEN8 - 6'h01) begin
                            cnt_r <= 6'h00;
                            if (cmd_ok) begin
                                cmd_r <= cmd_in;
                                len_r <= reg_len(cmd_in[5:0]);
                                state_r <= cmd_rd ? SRAP_ST_RD
                                                  : SRAP_ST_WR;
                            end
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                SRAP_ST_WR: begin
                    // write phase of 8, 16 or 24 bits
                    if (rise) begin
                        sh_r <= {sh_r[22:0], din_s_r};
                        if (cnt_r == len_r - 6'h01) begin
                            cnt_r <= 6'h00;
                            we_r <= 1'b1;
                            state_r <= SRAP_ST_CMD;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                SRAP_ST_RD: begin
                    // shift out msb first on falling edges
                    if (fall) begin
                        dout_r <= rdata[5'(len_r - 6'h01 - cnt_r)];
                    end
                    if (rise) begin
                        if (cnt_r == len_r - 6'h01) begin
                            cnt_r <= 6'h00;
                            dout_r <= 1'b1; // data line back to idle high
                            state_r <= SRAP_ST_CMD;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                default: state_r <= SRAP_ST_CMD;
            endcase
        end
    end
    // register memory; write data is the shifted word
    srap_regfile u_regs (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(clr_r),
        .we_i(we_r),
        .addr_i(sel),
        .wdata_i(sh_r),
        .rdata_o(rdata),
        .ctrl_o(ctrl)
    );
    // ctrl is not brought out of this block; it is only tied off here
    wire unused_ok = &{1'b0, ctrl};
endmodule
`default_nettype wire

// File: srap_pkg.sv
/*
 * srap_pkg: constants shared by the serial register access port.
 * assumes: nothing beyond a sv compiler; imported by the design modules.
 */
package srap_pkg;
    // register offsets
    localparam logic [5:0] SRAP_ADDR_CMD = 6'h00;
    localparam logic [5:0] SRAP_ADDR_IDENT = 6'h05;
    localparam logic [5:0] SRAP_ADDR_CTRL = 6'h01;
    localparam logic [5:0] SRAP_ADDR_ERREN = 6'h07;
    localparam logic [5:0] SRAP_ADDR_CHAN0 = 6'h09;
    localparam logic [5:0] SRAP_ADDR_CFG0 = 6'h19;
    // reset values
    localparam logic [7:0] SRAP_CMD_RST = 8'h00;
    localparam logic [15:0] SRAP_CHAN0_RST = 16'h8001;
    localparam logic [15:0] SRAP_CFG0_RST = 16'h0860;
    localparam logic [15:0] SRAP_CTRL_RST = 16'h0000;
    localparam logic [23:0] SRAP_ERREN_RST = 24'h000040;
    // identity fields, values arbitrary
    localparam logic [3:0] SRAP_PART_CODE = 4'h3;
    localparam logic [3:0] SRAP_DIE_REV = 4'h2;
    // command field positions
    localparam int SRAP_CMD_WEN_BIT = 7;
    localparam int SRAP_CMD_RD_BIT = 6;
    // resync run length in serial clocks
    localparam logic [6:0] SRAP_RESYNC_ONES = 7'h40;
    // internal master clock figure in hz
    localparam int SRAP_MCLK_HZ = 614400;
    localparam int SRAP_CLK_HZ = 10000000;
    localparam logic [4:0] SRAP_MCLK_DIV = 5'(SRAP_CLK_HZ / SRAP_MCLK_HZ / 2);
    // bit counts of a data phase
    localparam logic [5:0] SRAP_LEN8 = 6'h08;
    localparam logic [5:0] SRAP_LEN16 = 6'h10;
    localparam logic [5:0] SRAP_LEN24 = 6'h18;
    // interface states
    typedef enum logic [1:0] {
        SRAP_ST_CMD,
        SRAP_ST_WR,
        SRAP_ST_RD
    } srap_state_e;
endpackage

// File: srap_regfile.sv
/*
 * srap_regfile: small register memory for the access port.
 * assumes: same clock as the port; writes are single-cycle strobes.
 */
`timescale 1ns/1ns
`default_nettype none
module srap_regfile
    import srap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    input wire logic we_i,
    input wire logic [5:0] addr_i,
    input wire logic [23:0] wdata_i,
    output logic [23:0] rdata_o,
    output logic [15:0] ctrl_o
);
    logic [15:0] chan0_r; // channel 0 word
    logic [15:0] cfg0_r; // setup 0 word
    logic [15:0] ctrl_r; // converter control
    logic [23:0] erren_r; // diagnostic enables
    wire hit_chan0 = addr_i == SRAP_ADDR_CHAN0;
    wire hit_cfg0 = addr_i == SRAP_ADDR_CFG0;
    wire hit_ctrl = addr_i == SRAP_ADDR_CTRL;
    wire hit_erren = addr_i == SRAP_ADDR_ERREN;
    wire hit_ident = addr_i == SRAP_ADDR_IDENT;
    wire [23:0] rd_mux = hit_chan0 ? {8'h00, chan0_r} :
        hit_cfg0 ? {8'h00, cfg0_r} :
        hit_ctrl ? {8'h00, ctrl_r} :
        hit_erren ? erren_r :
        hit_ident ? {16'h0000, SRAP_PART_CODE, SRAP_DIE_REV} : 24'h000000;
    assign ctrl_o = ctrl_r;
    // storage; clr_i is the resync full reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chan0_r <= SRAP_CHAN0_RST;
            cfg0_r <= SRAP_CFG0_RST;
            ctrl_r <= SRAP_CTRL_RST;
            erren_r <= SRAP_ERREN_RST;
            rdata_o <= 24'h000000;
        end else if (clr_i) begin
            chan0_r <= SRAP_CHAN0_RST;
            cfg0_r <= SRAP_CFG0_RST;
            ctrl_r <= SRAP_CTRL_RST;
            erren_r <= SRAP_ERREN_RST;
            rdata_o <= 24'h000000;
        end else begin
            rdata_o <= rd_mux;
            if (we_i && hit_chan0) chan0_r <= wdata_i[15:0];
            if (we_i && hit_cfg0) cfg0_r <= wdata_i[15:0];
            if (we_i && hit_ctrl) ctrl_r <= wdata_i[15:0];
            if (we_i && hit_erren) erren_r <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// File: srap_port_properties.sv
/* srap_port_properties: timing checks on the serial port pins.
   assumes: bound onto srap_port; a single clock domain. */
`timescale 1ns/1ns
`default_nettype none
module srap_port_properties (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic mclk_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // master clock runs eight cycles high, eight low
    a_mclk_high: assert property (
        $rose(mclk_o) |-> mclk_o [*8] ##1 !mclk_o)
        else $error("master clock high phase wrong");
    a_mclk_low: assert property (
        $fell(mclk_o) |-> !mclk_o [*8] ##1 mclk_o)
        else $error("master clock low phase wrong");
    // output driven only inside a data phase
    a_oe_busy: assert property (dout_oe_o |-> busy_o)
        else $error("output enabled outside a transfer");
    // select held high leaves the port waiting for a command
    a_cs_abort: assert property (cs_b_i [*6] |-> !busy_o)
        else $error("transfer kept alive with select high");
    a_cs_oe_off: assert property (
        $rose(cs_b_i) |-> ##[0:5] !dout_oe_o)
        else $error("output still enabled after select rose");
    // read data holds for two cycles after the serial clock rises
    a_dout_steady: assert property (
        $rose(sclk_i) && dout_oe_o |=> $stable(dout_o) [*2])
        else $error("read data moved after a rising edge");
    // without serial edges the port stays waiting
    a_idle_quiet: assert property (
        sclk_i [*6] ##0 !busy_o |=> !busy_o)
        else $error("port left command wait without an edge");
    a_dout_idle: assert property (!busy_o [*8] |-> dout_o)
        else $error("data output not idle high");
    c_read: cover property ($rose(dout_oe_o));
    c_abort: cover property ($rose(cs_b_i) && busy_o);
    c_mclk: cover property ($rose(mclk_o));
endmodule
bind srap_port srap_port_properties chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sclk_i(sclk_i), .cs_b_i(cs_b_i), .din_i(din_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .mclk_o(mclk_o), .busy_o(busy_o));
`default_nettype wire

// File: srap_host_model.sv
/* srap_host_model: serial master for the port, mode 3, 800 ns bits.
   assumes: tasks are called by the bench; clk_i is the bench clock. */
`timescale 1ns/1ns
`default_nettype none
module srap_host_model (
    input wire logic clk_i,
    input wire logic dout_i,
    output logic sclk_o,
    output logic cs_b_o,
    output logic din_o
);
    logic [31:0] rx; // bits taken during the last transfer
    initial begin
        sclk_o = 1'b1; // clock idles high
        cs_b_o = 1'b0; // select held low, three-wire use
        din_o = 1'b1;
        rx = 32'h0;
    end
    // n bits msb first: change on fall, take data in the high phase
    task automatic xfer(input logic [31:0] v, input int n);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            din_o = v[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (2) @(negedge clk_i);
            rx = {rx[30:0], dout_i};
            repeat (2) @(negedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
/* tb_top: self-checking bench for srap_port.
   assumes: srap_host_model drives the serial pins at falling edges. */
`timescale 1ns/1ns
`default_nettype none
module tb_top import srap_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    wire sclk, cs_b, din, dout, dout_oe, mclk, busy;
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 63;
    logic [23:0] exp_q[$]; // expected read words, oldest first
    event got; // a read word has arrived
    always #50 clk_i = ~clk_i;
    srap_port dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
        .cs_b_i(cs_b), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
        .mclk_o(mclk), .busy_o(busy));
    srap_host_model h_u (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk),
        .cs_b_o(cs_b), .din_o(din));
    task end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [23:0] a, input logic [23:0] e);
        cmp_count++;
        if (a !== e) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, a, e);
        end
    endtask
    // note the expected word, then read register a of n bits
    task automatic rd(input logic [5:0] a, input int n, input logic [23:0] e);
        exp_q.push_back(e);
        h_u.xfer(32'({2'b01, a}), 8);
        h_u.xfer(32'($random(seed)), n);
        ->got;
        @(negedge clk_i); // watcher takes rx before the next frame clears it
    endtask
    task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
        h_u.xfer(32'({2'b00, a}), 8);
        h_u.xfer(32'(d), n);
    endtask
    // watcher: compare each arriving word with the oldest note
    always @(got) begin
        chk(h_u.rx[23:0], exp_q.pop_front());
    end
    initial begin
        logic [15:0] w;
        logic [23:0] e;
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk({23'h0, dout}, 24'h1);
        chk({23'h0, busy}, 24'h0);
        rd(SRAP_ADDR_IDENT, 8, {16'h0, SRAP_PART_CODE, SRAP_DIE_REV});
        rd(SRAP_ADDR_CTRL, 16, 24'(SRAP_CTRL_RST));
        rd(SRAP_ADDR_ERREN, 24, SRAP_ERREN_RST);
        rd(SRAP_ADDR_CHAN0, 16, 24'h8001);
        rd(SRAP_ADDR_CFG0, 16, 24'(SRAP_CFG0_RST));
        rd(6'h0a, 16, 24'h0);
        w = 16'($random(seed));
        e = 24'($random(seed));
        wr(SRAP_ADDR_CTRL, 16, 24'(w));
        wr(SRAP_ADDR_ERREN, 24, e);
        rd(SRAP_ADDR_ERREN, 24, e);
        wr(SRAP_ADDR_IDENT, 8, 24'h0);
        rd(SRAP_ADDR_IDENT, 8, {16'h0, SRAP_PART_CODE, SRAP_DIE_REV});
        // write gate high: command refused, next byte is a command
        h_u.xfer(32'h81, 8);
        rd(SRAP_ADDR_CTRL, 16, 24'(w));
        // select raised in mid-write aborts it
        h_u.xfer(32'h01, 8);
        h_u.xfer(32'h00, 8);
        h_u.cs_b_o = 1'b1;
        repeat (10) @(negedge clk_i);
        h_u.cs_b_o = 1'b0;
        repeat (4) @(negedge clk_i);
        rd(SRAP_ADDR_CTRL, 16, 24'(w));
        // select raised in mid-read drops the output and idles the line
        h_u.xfer(32'({2'b01, SRAP_ADDR_IDENT}), 8);
        h_u.xfer(32'($random(seed)), 4);
        h_u.cs_b_o = 1'b1;
        repeat (10) @(negedge clk_i);
        chk({23'h0, busy}, 24'h0);
        chk({23'h0, dout_oe}, 24'h0);
        chk({23'h0, dout}, 24'h1);
        h_u.cs_b_o = 1'b0;
        repeat (4) @(negedge clk_i);
        rd(SRAP_ADDR_IDENT, 8, {16'h0, SRAP_PART_CODE, SRAP_DIE_REV});
        // refused byte ending in zeros clears any run of ones left behind
        h_u.xfer(32'h80, 8);
        // sixty-four ones reset the whole device
        h_u.xfer(32'hffffffff, 32);
        h_u.xfer(32'hffffffff, 32);
        repeat (10) @(negedge clk_i);
        rd(SRAP_ADDR_CTRL, 16, 24'(SRAP_CTRL_RST));
        rd(SRAP_ADDR_ERREN, 24, SRAP_ERREN_RST);
        repeat (20) @(negedge clk_i);
        end_of_test();
    end
    // watchdog: far beyond the length of the sequence above
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
